// File: core/peq_qualifier.sv
/*
 Performance event qualifier for codes 16H..21H with its counter.
 Assumes all event sources are synchronous to sys_clk and that
 the counter select and enable come from elsewhere in the core.
*/
`timescale 1ns/1ps

// Summary of operation
// - Code 16H adds instructions completed per clock, two at most, fault handler entry counting as one.
// - Every taken hardware or software interrupt or exception also adds to code 16H.
// - A repeated string instruction adds one to code 16H however many iterations it runs.
// - Each halt adds one to code 16H no matter how long the core stays halted.
// - Code 17H counts like 16H but only instructions executed in the second pipe.
// - Code 18H adds one each clock a bus cycle runs, including hold acknowledge, address hold and back-off clocks.
// - Code 19H counts clocks where full write buffers stall a read miss, write miss or shared-line write hit, never for I/O.
// - Code 1AH counts clocks stalled on a data read, including data TLB miss handling and unbypassed reads during a fill.
// - Code 1BH adds one per stall on a write to an exclusive or modified line.
// - Code 1CH counts locked bus cycles once, on their read portion.
// - A split locked cycle adds two to code 1CH.
// - A locked cycle restarted after back-off is not counted again.
// - Code 1DH counts I/O bus cycles, one per start even for a split cycle, no restarted cycles.
// - Code 1EH counts noncacheable non-I/O memory read cycles, no restarted cycles.
// - Code 1FH flags an interlock when either execute stage writes a base or index register used in either address stage.
// - Interlocks in both pipes in one clock add two to code 1FH.
module peq_qualifier (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire peq_pkg::peq_code_t ev_sel,
	input wire logic count_en,
	input wire logic u_done,
	input wire logic v_done,
	input wire logic u_rep,
	input wire logic u_rep_last,
	input wire logic trap_taken,
	input wire logic halt_instr,
	input wire logic bus_start,
	input wire logic bus_active,
	input wire logic hold_ack,
	input wire logic addr_hold,
	input wire logic backoff_n,
	input wire logic bus_lock,
	input wire logic lock_read,
	input wire logic split_cycle,
	input wire logic bus_io,
	input wire logic bus_read,
	input wire logic bus_nc,
	input wire logic wbuf_full,
	input wire logic rd_miss,
	input wire logic wr_miss,
	input wire logic wr_hit_shared,
	input wire logic io_access,
	input wire logic dread_wait,
	input wire logic dtlb_walk,
	input wire logic fill_nobypass,
	input wire logic wr_em_stall,
	input wire logic u_ex_wr,
	input wire peq_pkg::peq_reg_t u_ex_reg,
	input wire logic v_ex_wr,
	input wire peq_pkg::peq_reg_t v_ex_reg,
	input wire logic [1:0] d2_base_vld,
	input wire logic [1:0] d2_idx_vld,
	input wire peq_pkg::peq_reg_t u_d2_base,
	input wire peq_pkg::peq_reg_t u_d2_idx,
	input wire peq_pkg::peq_reg_t v_d2_base,
	input wire peq_pkg::peq_reg_t v_d2_idx,
	output logic [1:0] event_inc_q,
	output logic [peq_pkg::CNT_W-1:0] event_count_q
);
	import peq_pkg::*;

	typedef struct packed {
		peq_rep_t rep;
		logic halt_seen;
		logic em_seen;
		peq_inc_t inc;
		logic [CNT_W-1:0] cnt;
	} peq_top_st_t;

	peq_top_st_t st_q;
	peq_top_st_t st_d;
	peq_evt_if ev ();
	logic u_cnt;
	logic halt_edge;
	logic bus_busy;
	logic [2:0] instr_sum;
	peq_inc_t instr_inc;

	// ========================================
	// Helper hookup
	assign ev.bus_start = bus_start;
	assign ev.bus_active = bus_active;
	assign ev.backoff_n = backoff_n;
	assign ev.bus_lock = bus_lock;
	assign ev.lock_read = lock_read;
	assign ev.split_cycle = split_cycle;
	assign ev.bus_io = bus_io;
	assign ev.bus_read = bus_read;
	assign ev.bus_nc = bus_nc;
	assign ev.u_ex_wr = u_ex_wr;
	assign ev.u_ex_reg = u_ex_reg;
	assign ev.v_ex_wr = v_ex_wr;
	assign ev.v_ex_reg = v_ex_reg;
	assign ev.d2_base_vld = d2_base_vld;
	assign ev.d2_idx_vld = d2_idx_vld;
	assign ev.d2_base[0] = u_d2_base;
	assign ev.d2_base[1] = v_d2_base;
	assign ev.d2_idx[0] = u_d2_idx;
	assign ev.d2_idx[1] = v_d2_idx;

	peq_bus_track u_trk (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.ev (ev.trk)
	);

	peq_agi_detect u_agi (
		.ev (ev.agi)
	);

	// ========================================
	// Instruction qualification
	always_comb
	begin
		// Only the first iteration of a repeated string counts
		u_cnt = u_done && (!u_rep || st_q.rep == REP_IDLE);
		// Halt counted once on entry
		halt_edge = halt_instr && !st_q.halt_seen;
		instr_sum = {2'h0, u_cnt} + {2'h0, v_done}
			+ {2'h0, trap_taken} + {2'h0, halt_edge};
		// Core retires at most two per clock
		if (instr_sum > {1'b0, INC_TWO})
		begin
			instr_inc = INC_TWO;
		end
		else
		begin
			instr_inc = instr_sum[1:0];
		end
		bus_busy = bus_active || hold_ack || addr_hold
			|| !backoff_n;
	end

	// ========================================
	// Event select and counter
	always_comb
	begin
		st_d = st_q;
		st_d.halt_seen = halt_instr;
		st_d.em_seen = wr_em_stall;
		case (st_q.rep)
			REP_IDLE:
			begin
				if (u_done && u_rep && !u_rep_last)
				begin
					st_d.rep = REP_LOOP;
				end
			end
			REP_LOOP:
			begin
				if (u_done && (!u_rep || u_rep_last))
				begin
					st_d.rep = REP_IDLE;
				end
			end
			default:
			begin
				st_d.rep = REP_IDLE;
			end
		endcase
		case (ev_sel)
			EV_INSTR:
			begin
				st_d.inc = instr_inc;
			end
			EV_INSTR_V:
			begin
				st_d.inc = {1'b0, v_done};
			end
			EV_BUS_BUSY:
			begin
				st_d.inc = {1'b0, bus_busy};
			end
			EV_WBUF:
			begin
				st_d.inc = {1'b0, wbuf_full && !io_access
					&& (rd_miss || wr_miss || wr_hit_shared)};
			end
			EV_RDWAIT:
			begin
				st_d.inc = {1'b0, dread_wait || dtlb_walk
					|| fill_nobypass};
			end
			EV_WR_EM:
			begin
				st_d.inc = {1'b0, wr_em_stall && !st_q.em_seen};
			end
			EV_LOCK:
			begin
				st_d.inc = ev.lock_cnt;
			end
			EV_IO:
			begin
				st_d.inc = {1'b0, ev.io_cnt};
			end
			EV_NCRD:
			begin
				st_d.inc = {1'b0, ev.ncrd_cnt};
			end
			EV_AGI:
			begin
				st_d.inc = {1'b0, ev.agi_u}
					+ {1'b0, ev.agi_v};
			end
			default:
			begin
				st_d.inc = INC_ZERO;
			end
		endcase
		if (!count_en)
		begin
			st_d.inc = INC_ZERO;
		end
		st_d.cnt = st_q.cnt + {{(CNT_W-2){1'b0}}, st_d.inc};
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_q.rep <= REP_IDLE;
			st_q.halt_seen <= 1'b0;
			st_q.em_seen <= 1'b0;
			st_q.inc <= INC_ZERO;
			st_q.cnt <= CNT_RST;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	assign event_inc_q = st_q.inc;
	assign event_count_q = st_q.cnt;

	// ========================================
	// Checks
	sequence rep_first_s;
		ev_sel == EV_INSTR && u_done && u_rep && !u_rep_last;
	endsequence

	sequence rep_next_s;
		ev_sel == EV_INSTR && count_en && u_done && u_rep
			&& !v_done && !trap_taken && !halt_instr;
	endsequence

	rep_once_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		rep_first_s ##1 rep_next_s |=> event_inc_q == INC_ZERO)
		else $error("repeat string counted more than once");

	halt_once_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev_sel == EV_INSTR && count_en && halt_instr
			&& $past(halt_instr) && !u_done && !v_done
			&& !trap_taken) |=> event_inc_q == INC_ZERO)
		else $error("held halt counted again");

	instr_cap_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev_sel == EV_INSTR && count_en && u_done && v_done
			&& trap_taken && !u_rep) |=> event_inc_q == INC_TWO)
		else $error("instruction count not capped at two");

	vpipe_only_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev_sel == EV_INSTR_V && count_en)
		|=> event_inc_q == {1'b0, $past(v_done)})
		else $error("second pipe count wrong");

	bus_busy_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev_sel == EV_BUS_BUSY && count_en && !backoff_n)
		|=> event_inc_q == INC_ONE)
		else $error("back-off clock not counted as bus busy");

	wbuf_io_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev_sel == EV_WBUF && io_access) |=> event_inc_q == INC_ZERO)
		else $error("I/O write buffer stall counted");

	split_lock_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev_sel == EV_LOCK && count_en && bus_start && bus_lock
			&& lock_read && split_cycle && !u_trk.st_q.restart_pend)
		|=> event_inc_q == INC_TWO)
		else $error("split locked cycle not counted twice");

	agi_both_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev_sel == EV_AGI && count_en && ev.agi_u && ev.agi_v)
		|=> event_inc_q == INC_TWO)
		else $error("dual interlock not counted twice");

	reserved_zero_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev_sel == EV_RSV0 || ev_sel == EV_RSV1) |=> event_inc_q
		== INC_ZERO && event_count_q == $past(event_count_q))
		else $error("reserved code incremented counter");

	count_sum_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		##1 event_count_q == $past(event_count_q)
		+ {{(CNT_W-2){1'b0}}, event_inc_q})
		else $error("counter did not add increment");

	enable_off_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		!count_en |=> event_inc_q == INC_ZERO)
		else $error("disabled counter incremented");

	trap_count_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev_sel == EV_INSTR && count_en && trap_taken && !u_done
			&& !v_done && !halt_instr) |=> event_inc_q == INC_ONE)
		else $error("taken trap not counted");

	wbuf_stall_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev_sel == EV_WBUF && count_en && wbuf_full && !io_access
			&& rd_miss) |=> event_inc_q == INC_ONE)
		else $error("write buffer stall not counted");

	read_wait_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev_sel == EV_RDWAIT && count_en && dtlb_walk)
		|=> event_inc_q == INC_ONE)
		else $error("data TLB walk clock not counted");

	sequence em_hold_s;
		ev_sel == EV_WR_EM && count_en && wr_em_stall;
	endsequence

	em_once_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		em_hold_s ##1 em_hold_s |=> event_inc_q == INC_ZERO)
		else $error("held stall counted again");

	lock_single_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev_sel == EV_LOCK && count_en && bus_start && bus_lock
			&& lock_read && !split_cycle && !u_trk.st_q.restart_pend)
		|=> event_inc_q == INC_ONE)
		else $error("locked read not counted once");
endmodule // peq_qualifier

// File: pkg/peq_pkg.sv
/*
 Shared constants and types for the performance event qualifier.
 Assumes one core clock and one event counter fed by this logic.
*/
package peq_pkg;
	localparam logic [7:0] EV_INSTR = 8'h16;
	localparam logic [7:0] EV_INSTR_V = 8'h17;
	localparam logic [7:0] EV_BUS_BUSY = 8'h18;
	localparam logic [7:0] EV_WBUF = 8'h19;
	localparam logic [7:0] EV_RDWAIT = 8'h1A;
	localparam logic [7:0] EV_WR_EM = 8'h1B;
	localparam logic [7:0] EV_LOCK = 8'h1C;
	localparam logic [7:0] EV_IO = 8'h1D;
	localparam logic [7:0] EV_NCRD = 8'h1E;
	localparam logic [7:0] EV_AGI = 8'h1F;
	localparam logic [7:0] EV_RSV0 = 8'h20;
	localparam logic [7:0] EV_RSV1 = 8'h21;
	localparam int CNT_W = 40;
	localparam int REG_W = 3;
	localparam logic [1:0] INC_ZERO = 2'h0;
	localparam logic [1:0] INC_ONE = 2'h1;
	localparam logic [1:0] INC_TWO = 2'h2;
	localparam logic [CNT_W-1:0] CNT_RST = 40'h00_0000_0000;
	typedef logic [1:0] peq_inc_t;
	typedef logic [7:0] peq_code_t;
	typedef logic [REG_W-1:0] peq_reg_t;
	typedef enum logic {REP_IDLE, REP_LOOP} peq_rep_t;
endpackage

// File: pkg/peq_evt_if.sv
/*
 Internal carrier between the qualifier top and its two helpers.
 Assumes all signals are in the core clock domain.
*/
`timescale 1ns/1ps
interface peq_evt_if;
	import peq_pkg::*;
	logic bus_start;
	logic bus_active;
	logic backoff_n;
	logic bus_lock;
	logic lock_read;
	logic split_cycle;
	logic bus_io;
	logic bus_read;
	logic bus_nc;
	peq_inc_t lock_cnt;
	logic io_cnt;
	logic ncrd_cnt;
	logic u_ex_wr;
	peq_reg_t u_ex_reg;
	logic v_ex_wr;
	peq_reg_t v_ex_reg;
	logic [1:0] d2_base_vld;
	logic [1:0] d2_idx_vld;
	peq_reg_t d2_base [2];
	peq_reg_t d2_idx [2];
	logic agi_u;
	logic agi_v;
	modport top (output bus_start, bus_active, backoff_n, bus_lock,
		lock_read, split_cycle, bus_io, bus_read, bus_nc, u_ex_wr,
		u_ex_reg, v_ex_wr, v_ex_reg, d2_base_vld, d2_idx_vld, d2_base,
		d2_idx, input lock_cnt, io_cnt, ncrd_cnt, agi_u, agi_v);
	modport trk (input bus_start, bus_active, backoff_n, bus_lock,
		lock_read, split_cycle, bus_io, bus_read, bus_nc,
		output lock_cnt, io_cnt, ncrd_cnt);
	modport agi (input u_ex_wr, u_ex_reg, v_ex_wr, v_ex_reg,
		d2_base_vld, d2_idx_vld, d2_base, d2_idx, output agi_u, agi_v);
endinterface // peq_evt_if

// File: core/peq_bus_track.sv
/*
 Bus cycle accounting: locked, I/O and noncacheable read starts.
 Assumes bus_start pulses once per bus cycle start on the core clock.
*/
`timescale 1ns/1ps
module peq_bus_track (
	input wire logic sys_clk,
	input wire logic reset_n,
	peq_evt_if.trk ev
);
	import peq_pkg::*;

	typedef struct packed {
		logic restart_pend;
	} peq_trk_st_t;

	peq_trk_st_t st_q;
	peq_trk_st_t st_d;
	logic fresh;

	// ========================================
	// Restart tracking
	always_comb
	begin
		st_d = st_q;
		fresh = ev.bus_start && !st_q.restart_pend;
		if (ev.bus_start)
		begin
			st_d.restart_pend = 1'b0;
		end
		// Backed-off cycle will be restarted, skip its recount
		if (ev.bus_active && !ev.backoff_n)
		begin
			st_d.restart_pend = 1'b1;
		end
		ev.lock_cnt = INC_ZERO;
		if (fresh && ev.bus_lock && ev.lock_read)
		begin
			ev.lock_cnt = ev.split_cycle ? INC_TWO : INC_ONE;
		end
		ev.io_cnt = fresh && ev.bus_io;
		ev.ncrd_cnt = fresh && ev.bus_read && ev.bus_nc && !ev.bus_io;
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			st_q <= '0;
		end
		else
		begin
			st_q <= st_d;
		end
	end

	// ========================================
	// Checks
	restart_nocount_a: assert property (@(posedge sys_clk)
		disable iff (!reset_n)
		(ev.bus_active && !ev.backoff_n) ##1 ev.bus_start
		|-> ev.lock_cnt == INC_ZERO && !ev.io_cnt && !ev.ncrd_cnt)
		else $error("restarted bus cycle counted again");
endmodule // peq_bus_track

// File: core/peq_agi_detect.sv
/*
 Address generation interlock detection for both pipes.
 Assumes register indices are valid only with their valid bits.
*/
`timescale 1ns/1ps
module peq_agi_detect (
	peq_evt_if.agi ev
);
	import peq_pkg::*;

	function automatic logic reg_hit(input logic wr, input peq_reg_t r,
		input logic bv, input peq_reg_t b, input logic iv,
		input peq_reg_t i);
		reg_hit = wr && ((bv && b == r) || (iv && i == r));
	endfunction

	// ========================================
	// Either execute stage against each address stage
	always_comb
	begin
		ev.agi_u = reg_hit(ev.u_ex_wr, ev.u_ex_reg, ev.d2_base_vld[0],
			ev.d2_base[0], ev.d2_idx_vld[0], ev.d2_idx[0])
			|| reg_hit(ev.v_ex_wr, ev.v_ex_reg, ev.d2_base_vld[0],
			ev.d2_base[0], ev.d2_idx_vld[0], ev.d2_idx[0]);
		ev.agi_v = reg_hit(ev.u_ex_wr, ev.u_ex_reg, ev.d2_base_vld[1],
			ev.d2_base[1], ev.d2_idx_vld[1], ev.d2_idx[1])
			|| reg_hit(ev.v_ex_wr, ev.v_ex_reg, ev.d2_base_vld[1],
			ev.d2_base[1], ev.d2_idx_vld[1], ev.d2_idx[1]);
	end
endmodule // peq_agi_detect

// File: sim/peq_bus_src.sv
/*
 Bus unit model: cycle starts, attributes, hold and back-off clocks.
 Assumes the bench hands fresh random bits after each rising edge.
*/
`timescale 1ns/1ps
module peq_bus_src (
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic [31:0] rnd,
	output logic bus_start,
	output logic bus_active,
	output logic hold_ack,
	output logic addr_hold,
	output logic backoff_n,
	output logic [5:0] attr
);
	logic [1:0] left;
	always @(negedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{bus_start, bus_active, hold_ack, addr_hold} <= 4'h0;
			backoff_n <= 1'b1;
			attr <= 6'h00;
			left <= 2'h0;
		end
		else if (left == 2'h0 && rnd[0])
		begin
			// Start pulse, attributes valid with it
			{bus_start, bus_active, hold_ack, addr_hold} <= 4'hC;
			backoff_n <= 1'b1;
			attr <= rnd[6:1];
			left <= rnd[8:7];
		end
		else
		begin
			// Attributes no longer valid: show their inverse
			bus_start <= 1'b0;
			attr <= ~attr;
			bus_active <= left != 2'h0;
			hold_ack <= left != 2'h0 && rnd[9];
			addr_hold <= left != 2'h0 && rnd[10];
			backoff_n <= !(left != 2'h0 && rnd[11] && rnd[12]);
			if (left != 2'h0)
				left <= left - 2'h1;
		end
	end
endmodule // peq_bus_src

// File: sim/perf_event_qualifier_bench.sv
/*
 Self-checking bench: random events for every code 15H..22H.
 Assumes the qualifier answers one clock after sampling its inputs.
*/
`timescale 1ns/1ps
module perf_event_qualifier_bench;
	import peq_pkg::*;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	peq_code_t ev_sel = 8'h00;
	logic count_en = 1'b0;
	logic u_done = '0, v_done = '0, u_rep = '0, u_rep_last = '0;
	logic trap_taken = '0, halt_instr = '0, wbuf_full = '0, rd_miss = '0;
	logic wr_miss = '0, wr_hit_shared = '0, io_access = '0;
	logic dread_wait = '0, dtlb_walk = '0, fill_nobypass = '0;
	logic wr_em_stall = '0, u_ex_wr = '0, v_ex_wr = '0;
	peq_reg_t u_ex_reg = '0, v_ex_reg = '0, u_d2_base = '0, u_d2_idx = '0;
	peq_reg_t v_d2_base = '0, v_d2_idx = '0;
	logic [1:0] d2_base_vld = '0, d2_idx_vld = '0;
	logic bus_start, bus_active, hold_ack, addr_hold, backoff_n;
	logic bus_lock, lock_read, split_cycle, bus_io, bus_read, bus_nc;
	logic [1:0] event_inc_q;
	logic [CNT_W-1:0] event_count_q;
	logic [31:0] seed = 32'h5D2A;
	logic [31:0] bus_rnd = 32'h5D2A;
	peq_inc_t exp_inc;
	logic [CNT_W-1:0] exp_cnt;
	logic halt_p, em_p, rep_loop, pend;
	int miscompares = 0;
	int samples_checked = 0;
	always #2.5 sys_clk = ~sys_clk;
	peq_bus_src bus (.sys_clk, .reset_n, .rnd(bus_rnd), .bus_start,
		.bus_active, .hold_ack, .addr_hold, .backoff_n,
		.attr({bus_lock, lock_read, split_cycle, bus_io, bus_read, bus_nc}));
	peq_qualifier dut (.sys_clk, .reset_n, .ev_sel, .count_en, .u_done,
		.v_done, .u_rep, .u_rep_last, .trap_taken, .halt_instr,
		.bus_start, .bus_active, .hold_ack, .addr_hold, .backoff_n,
		.bus_lock, .lock_read, .split_cycle, .bus_io, .bus_read, .bus_nc,
		.wbuf_full, .rd_miss, .wr_miss, .wr_hit_shared, .io_access,
		.dread_wait, .dtlb_walk, .fill_nobypass, .wr_em_stall, .u_ex_wr,
		.u_ex_reg, .v_ex_wr, .v_ex_reg, .d2_base_vld, .d2_idx_vld,
		.u_d2_base, .u_d2_idx, .v_d2_base, .v_d2_idx, .event_inc_q,
		.event_count_q);
	// ==========================================
	// Expectation
	function automatic logic [31:0] xs(input logic [31:0] x);
		x ^= x << 13;
		x ^= x >> 17;
		x ^= x << 5;
		return x;
	endfunction
	function automatic logic wr(input peq_reg_t r);
		return (u_ex_wr && u_ex_reg == r) || (v_ex_wr && v_ex_reg == r);
	endfunction
	function automatic peq_inc_t calc(input peq_code_t c);
		logic [2:0] s;
		logic fresh;
		logic au;
		logic av;
		s = 3'(u_done && !(u_rep && rep_loop)) + 3'(v_done);
		s = s + 3'(trap_taken) + 3'(halt_instr && !halt_p);
		fresh = bus_start && !pend;
		au = (d2_base_vld[0] && wr(u_d2_base)) || (d2_idx_vld[0] && wr(u_d2_idx));
		av = (d2_base_vld[1] && wr(v_d2_base)) || (d2_idx_vld[1] && wr(v_d2_idx));
		if (!count_en)
			return INC_ZERO;
		case (c)
			EV_INSTR: return (s > 3'h2) ? INC_TWO : s[1:0];
			EV_INSTR_V: return {1'b0, v_done};
			EV_BUS_BUSY: return {1'b0, bus_active || hold_ack ||
				addr_hold || !backoff_n};
			EV_WBUF: return {1'b0, wbuf_full && !io_access &&
				(rd_miss || wr_miss || wr_hit_shared)};
			EV_RDWAIT: return {1'b0, dread_wait || dtlb_walk || fill_nobypass};
			EV_WR_EM: return {1'b0, wr_em_stall && !em_p};
			EV_LOCK: return !(fresh && bus_lock && lock_read) ? INC_ZERO :
				(split_cycle ? INC_TWO : INC_ONE);
			EV_IO: return {1'b0, fresh && bus_io};
			EV_NCRD: return {1'b0, fresh && bus_read && bus_nc && !bus_io};
			EV_AGI: return 2'(au) + 2'(av);
			default: return INC_ZERO;
		endcase
	endfunction
	always @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			exp_inc = INC_ZERO;
			exp_cnt = CNT_RST;
			{halt_p, em_p, rep_loop, pend} = 4'h0;
		end
		else
		begin
			exp_inc = calc(ev_sel);
			exp_cnt = exp_cnt + CNT_W'(exp_inc);
			halt_p = halt_instr;
			em_p = wr_em_stall;
			if (u_done)
				rep_loop = u_rep && !u_rep_last;
			if (bus_active && !backoff_n)
				pend = 1'b1;
			else if (bus_start)
				pend = 1'b0;
		end
	end
	always @(posedge sys_clk)
		bus_rnd <= xs(bus_rnd);
	// ==========================================
	// Checking and verdict
	task automatic check(input string nm, input logic [CNT_W-1:0] e,
		input logic [CNT_W-1:0] g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic print_verdict;
		if (miscompares == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial
	begin
		#100000;
		miscompares++;
		print_verdict;
	end
	// ==========================================
	// Stimulus
	initial
	begin
		repeat (10) @(negedge sys_clk);
		reset_n = 1'b1;
		for (int c = 8'h15; c <= 8'h22; c++)
		begin
			ev_sel = peq_code_t'(c);
			for (int i = 0; i < 300; i++)
			begin
				@(negedge sys_clk);
				check("inc", CNT_W'(exp_inc), CNT_W'(event_inc_q));
				check("count", exp_cnt, event_count_q);
				seed = xs(seed);
				{u_done, v_done, u_rep, u_rep_last, trap_taken, halt_instr,
					wbuf_full, rd_miss, wr_miss, wr_hit_shared, io_access,
					dread_wait, dtlb_walk, fill_nobypass, wr_em_stall,
					u_ex_wr, v_ex_wr} = seed[16:0];
				count_en = seed[30] | seed[31];
				seed = xs(seed);
				{u_ex_reg, v_ex_reg, d2_base_vld, d2_idx_vld, u_d2_base,
					u_d2_idx, v_d2_base, v_d2_idx} = seed[21:0];
				// Long halt and a five-pass repeated string
				if (i >= 100 && i < 112)
					{halt_instr, wr_em_stall, count_en} = 3'h7;
				if (i >= 106 && i < 111)
					{u_done, u_rep, u_rep_last} = {2'h3, i == 110};
			end
		end
		print_verdict;
	end
endmodule // perf_event_qualifier_bench
